// ==== dss_regs.svh ====
`ifndef DSS_REGS_SVH
`define DSS_REGS_SVH

// second sense byte positions
`define DSS_SB2_INIT_STATE    0
`define DSS_SB2_READY_TRANS   1
`define DSS_SB2_TABLE_MOD     5
`define DSS_SB2_IN_PROTECT    6
`define DSS_SB2_RSVD_MASK     8'h1c
// third sense byte positions
`define DSS_SB3_SPIN_ERR      0
`define DSS_SB3_OSC_TRACK     1
`define DSS_SB3_GUARD_BAND    2
`define DSS_SB3_OUTER_STOP    3
`define DSS_SB3_PARK_LOCK     4
`define DSS_SB3_RSVD_MASK     8'he0
// self test result positions
`define DSS_DIAG_RAM          0
`define DSS_DIAG_PROM1        1
`define DSS_DIAG_PROM2        2
`define DSS_DIAG_RSVD_MASK    8'hf8
// table modification attribute
`define DSS_TABLE_MOD_ATTR    8'h0e
`define DSS_TABLE_MOD_BIT     4
// reset values
`define DSS_SB2_RESET         8'h00
`define DSS_SB3_RESET         8'h00
`define DSS_DIAG_RESET        8'h00
// timing
`define DSS_CLK_HZ            50000000
`define DSS_CLK_NS            20
`define DSS_SPIN_TIMEOUT_S    15
`define DSS_SPIN_CYCLES       (`DSS_SPIN_TIMEOUT_S * `DSS_CLK_HZ)
`define DSS_INDEX_WIDTH_NS    2500
`define DSS_INDEX_CYCLES      ((`DSS_INDEX_WIDTH_NS + `DSS_CLK_NS - 1) / `DSS_CLK_NS)

`endif

// ==== dss_pkg.sv ====
package dss_pkg;

   // one-cycle command strobes from the command decoder
   typedef struct packed {
      logic clear_attention;
      logic clear_fault;
      logic rezero;
      logic seek;
      logic seek_outer_stop;
      logic read_permit;
      logic write_permit;
      logic selective_reset;
      logic write_ctl_disable;
      logic write_ctl_enable;
      logic report_sense2;
      logic report_sense3;
      logic report_diag;
   } dss_cmd_t;

   typedef enum logic [1:0] {
      DSS_SPIN_IDLE = 2'b00,
      DSS_SPIN_UP   = 2'b01,
      DSS_SPIN_DOWN = 2'b10
   } dss_spin_state_t;

   typedef enum logic {
      DSS_RZ_IDLE = 1'b0,
      DSS_RZ_RUN  = 1'b1
   } dss_rezero_state_t;

endpackage

// ==== dss_status.sv ====
// Summary of operation
// - initial-state flag set when initialize ends; clear attention clears; raises attention
// - ready-transition flag set on any not-ready change; cleared by clear attention
// - table-modified flag set when attribute 0E bit 4 rises; raises attention
// - protected flag set when write disabled or heads in protected zone
// - protect switch sets flag after next seek/rezero/permit/reset; inhibits writes at once
// - protected flag clears only outside zones when write control enables writing
// - reserved bits of all three status bytes always read zero
// - third byte and self-test byte returned only for their own report commands
// - spin error after 15 s without speed change; raises attention; clear fault clears
// - oscillator or off-track write sets flag, not ready, attention; rezero clears
// - heads outside data area sets guard flag, not ready, attention; rezero clears
// - guard error starts automatic rezero, busy held for its whole duration
// - seek to outer stop sets outer-stop flag and not ready
// - park-lock flag follows engaged positioner lock on fitted drives
// - memory self-test failures flagged permanently and keep drive not ready
// - strobe rising edge with direction active captures own select line; acknowledge when selected
// - strobe edge with direction active and no line asserted deselects every drive; a poll keeps selection
// - command errors and other events set attention at once, before acknowledge
// - clear attention releases attention; clear fault releases it only while no fault persists
// - poll: strobe with direction inactive puts attention on own line, ack if selected
// - one index per revolution, equal sectors, none at index, gated by selection
// - general status bit 5 is the OR of the second sense byte
// - first sense byte bit 6 is the OR of the third sense byte
// - first sense byte bit 7 is the OR of the self-test result byte
`timescale 1ns/1ps
`include "dss_regs.svh"

module dss_status #(
   parameter int MY_LINE       = 0,
   parameter bit HAS_PARK_LOCK = 1'b1,
   parameter int SPIN_CYCLES   = `DSS_SPIN_CYCLES,
   parameter int SECTORS       = 32,
   parameter int SECTOR_CYCLES = 26000,
   parameter int PULSE_CYCLES  = `DSS_INDEX_CYCLES
) (
   input  wire logic            mclk,
   input  wire logic            rst,
   input  wire dss_pkg::dss_cmd_t cmd,
   input  wire logic            init_done,
   input  wire logic            not_ready_in,
   input  wire logic            table_mod_bit,
   input  wire logic            protect_switch,
   input  wire logic            heads_in_protected,
   input  wire logic            spin_up_start,
   input  wire logic            spin_down_start,
   input  wire logic            at_speed,
   input  wire logic            spun_down,
   input  wire logic            servo_phase_lock_oscillator_fault,
   input  wire logic            write_gate,
   input  wire logic            off_track,
   input  wire logic            heads_outside_data,
   input  wire logic            rezero_active,
   input  wire logic            outer_stop_active,
   input  wire logic            rezero_done,
   input  wire logic            park_lock_engaged,
   input  wire logic            ram_fail,
   input  wire logic            prom1_fail,
   input  wire logic            prom2_fail,
   input  wire logic            cmd_param_error,
   input  wire logic            op_complete,
   input  wire logic            other_error,
   input  wire logic            fault_persists,
   input  wire logic            attn_enable,
   input  wire logic            busy_in,
   input  wire logic            strobe,
   input  wire logic            bus_dir_out,
   input  wire logic [7:0]      bus_line_in,
   output logic                 bus_line_out,
   output logic                 bus_line_oe,
   output logic                 bus_ack,
   output logic                 busy,
   output logic                 attention,
   output logic                 not_ready,
   output logic                 write_inhibit,
   output logic                 auto_rezero_start,
   output logic                 index_pulse,
   output logic                 sector_pulse,
   output logic                 gs_sense2_any,
   output logic                 sb1_sense3_any,
   output logic                 sb1_diag_any,
   output logic [7:0]           resp_data,
   output logic                 resp_valid
);

   logic [7:0]  sb2_reg, sb2_next;
   logic [7:0]  sb3_reg, sb3_next;
   logic [7:0]  diag_reg, diag_next;
   logic        nr_next;
   logic        wr_disabled_reg;
   logic        protect_pending_reg;
   logic        table_mod_d_reg;
   logic        attn_latch_reg, attn_next, attn_set;
   logic        selected_reg, sel_next;
   logic        strobe_d_reg, strobe_rise;
   logic        polling_reg;
   logic [29:0] spin_cnt_reg;
   logic [15:0] sect_cnt_reg;
   logic [7:0]  sect_num_reg;
   logic        guard_cond;
   dss_pkg::dss_spin_state_t   spin_state_reg;
   dss_pkg::dss_rezero_state_t rz_state_reg;

   localparam logic [29:0] SPIN_LAST = 30'(SPIN_CYCLES - 1);
   localparam logic [15:0] SECT_LAST = 16'(SECTOR_CYCLES - 1);
   localparam logic [15:0] PULSE_W   = 16'(PULSE_CYCLES);
   localparam logic [7:0]  SECT_MAX  = 8'(SECTORS - 1);

   // guard band is legal only while the heads are being sent to a stop
   assign guard_cond = heads_outside_data & ~rezero_active & ~outer_stop_active
                       & (rz_state_reg == dss_pkg::DSS_RZ_IDLE);

   // next value of the status bytes; every set wins over a clear in the same cycle
   always_comb begin
      sb2_next  = sb2_reg;
      sb3_next  = sb3_reg;
      diag_next = diag_reg;
      if (cmd.clear_attention) begin
         sb2_next[`DSS_SB2_INIT_STATE]  = 1'b0;
         sb2_next[`DSS_SB2_READY_TRANS] = 1'b0;
         sb2_next[`DSS_SB2_TABLE_MOD]   = 1'b0;
      end
      if (init_done)
         sb2_next[`DSS_SB2_INIT_STATE] = 1'b1;
      if (table_mod_bit & ~table_mod_d_reg)
         sb2_next[`DSS_SB2_TABLE_MOD] = 1'b1;
      // protected area flag: clear only on an enabling write control outside zones
      if (cmd.write_ctl_enable & ~heads_in_protected)
         sb2_next[`DSS_SB2_IN_PROTECT] = 1'b0;
      // the enabling command ends the disabled state in its own cycle
      if (cmd.write_ctl_disable | (wr_disabled_reg & ~cmd.write_ctl_enable))
         sb2_next[`DSS_SB2_IN_PROTECT] = 1'b1;
      if (heads_in_protected & ~wr_disabled_reg & ~cmd.write_ctl_disable)
         sb2_next[`DSS_SB2_IN_PROTECT] = 1'b1;
      if (protect_pending_reg)
         sb2_next[`DSS_SB2_IN_PROTECT] = 1'b1;
      // third byte: fault clears first, then the sets
      if (cmd.clear_fault)
         sb3_next[`DSS_SB3_SPIN_ERR] = 1'b0;
      if (cmd.rezero) begin
         sb3_next[`DSS_SB3_OSC_TRACK]  = 1'b0;
         sb3_next[`DSS_SB3_GUARD_BAND] = 1'b0;
         sb3_next[`DSS_SB3_OUTER_STOP] = 1'b0;
      end
      if (spin_state_reg != dss_pkg::DSS_SPIN_IDLE && spin_cnt_reg == SPIN_LAST)
         sb3_next[`DSS_SB3_SPIN_ERR] = 1'b1;
      if (servo_phase_lock_oscillator_fault | (write_gate & off_track))
         sb3_next[`DSS_SB3_OSC_TRACK] = 1'b1;
      if (guard_cond)
         sb3_next[`DSS_SB3_GUARD_BAND] = 1'b1;
      if (cmd.seek_outer_stop)
         sb3_next[`DSS_SB3_OUTER_STOP] = 1'b1;
      sb3_next[`DSS_SB3_PARK_LOCK] = HAS_PARK_LOCK & park_lock_engaged;
      // self-test failures are sticky; only power-up reset removes them
      diag_next[`DSS_DIAG_RAM]   = diag_reg[`DSS_DIAG_RAM] | ram_fail;
      diag_next[`DSS_DIAG_PROM1] = diag_reg[`DSS_DIAG_PROM1] | prom1_fail;
      diag_next[`DSS_DIAG_PROM2] = diag_reg[`DSS_DIAG_PROM2] | prom2_fail;
      // not ready change is seen against the value about to be stored
      nr_next = not_ready_in | (|diag_next) | sb3_next[`DSS_SB3_OSC_TRACK]
                | sb3_next[`DSS_SB3_GUARD_BAND] | sb3_next[`DSS_SB3_OUTER_STOP];
      if (nr_next != not_ready)
         sb2_next[`DSS_SB2_READY_TRANS] = 1'b1;
      sb2_next  = sb2_next & ~`DSS_SB2_RSVD_MASK;
      sb2_next[7] = 1'b0;
      sb3_next  = sb3_next & ~`DSS_SB3_RSVD_MASK;
      diag_next = diag_next & ~`DSS_DIAG_RSVD_MASK;
   end

   // status byte storage
   always_ff @(posedge mclk) begin
      if (rst) begin
         sb2_reg   <= `DSS_SB2_RESET;
         sb3_reg   <= `DSS_SB3_RESET;
         diag_reg  <= `DSS_DIAG_RESET;
         not_ready <= 1'b0;
      end else begin
         sb2_reg   <= sb2_next;
         sb3_reg   <= sb3_next;
         diag_reg  <= diag_next;
         not_ready <= nr_next;
      end
   end

   // write protection state; the switch blocks writing without waiting
   always_ff @(posedge mclk) begin
      if (rst) begin
         wr_disabled_reg     <= 1'b0;
         protect_pending_reg <= 1'b0;
         write_inhibit       <= 1'b0;
         table_mod_d_reg     <= 1'b0;
      end else begin
         if (cmd.write_ctl_disable)
            wr_disabled_reg <= 1'b1;
         else if (cmd.write_ctl_enable)
            wr_disabled_reg <= 1'b0;
         protect_pending_reg <= protect_switch & (cmd.seek | cmd.rezero | cmd.read_permit
                                | cmd.write_permit | cmd.selective_reset);
         write_inhibit   <= protect_switch | wr_disabled_reg | cmd.write_ctl_disable;
         table_mod_d_reg <= table_mod_bit;
      end
   end

   // spin supervision; timer restarts on every new spin request
   always_ff @(posedge mclk) begin
      if (rst) begin
         spin_state_reg <= dss_pkg::DSS_SPIN_IDLE;
         spin_cnt_reg   <= 30'h0000_0000;
      end else if (spin_up_start) begin
         spin_state_reg <= dss_pkg::DSS_SPIN_UP;
         spin_cnt_reg   <= 30'h0000_0000;
      end else if (spin_down_start) begin
         spin_state_reg <= dss_pkg::DSS_SPIN_DOWN;
         spin_cnt_reg   <= 30'h0000_0000;
      end else begin
         case (spin_state_reg)
            dss_pkg::DSS_SPIN_UP, dss_pkg::DSS_SPIN_DOWN: begin
               if ((spin_state_reg == dss_pkg::DSS_SPIN_UP && at_speed)
                   || (spin_state_reg == dss_pkg::DSS_SPIN_DOWN && spun_down)
                   || spin_cnt_reg == SPIN_LAST)
                  spin_state_reg <= dss_pkg::DSS_SPIN_IDLE;
               spin_cnt_reg <= spin_cnt_reg + 30'h0000_0001;
            end
            default: begin
               spin_state_reg <= dss_pkg::DSS_SPIN_IDLE;
               spin_cnt_reg   <= 30'h0000_0000;
            end
         endcase
      end
   end

   // automatic rezero after a guard band error, busy for its duration
   always_ff @(posedge mclk) begin
      if (rst) begin
         rz_state_reg      <= dss_pkg::DSS_RZ_IDLE;
         auto_rezero_start <= 1'b0;
         busy              <= 1'b0;
      end else begin
         auto_rezero_start <= 1'b0;
         case (rz_state_reg)
            dss_pkg::DSS_RZ_IDLE: begin
               if (guard_cond) begin
                  rz_state_reg      <= dss_pkg::DSS_RZ_RUN;
                  auto_rezero_start <= 1'b1;
               end
            end
            dss_pkg::DSS_RZ_RUN: begin
               if (rezero_done)
                  rz_state_reg <= dss_pkg::DSS_RZ_IDLE;
            end
            default: rz_state_reg <= dss_pkg::DSS_RZ_IDLE;
         endcase
         busy <= busy_in | guard_cond | (rz_state_reg == dss_pkg::DSS_RZ_RUN
                 && !rezero_done);
      end
   end

   // attention latch; a raising event in a clear cycle keeps it set
   always_comb begin
      attn_set = (|(sb2_next & ~sb2_reg & 8'h23))
                 | (|(sb3_next & ~sb3_reg & 8'h07))
                 | cmd_param_error | op_complete | other_error;
      attn_next = attn_latch_reg;
      if (cmd.clear_attention || (cmd.clear_fault && !fault_persists))
         attn_next = 1'b0;
      if (attn_set)
         attn_next = 1'b1;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         attn_latch_reg <= 1'b0;
         attention      <= 1'b0;
      end else begin
         attn_latch_reg <= attn_next;
         attention      <= attn_next & attn_enable;
      end
   end

   // selection and attention poll on the strobe's rising edge
   assign strobe_rise = strobe & ~strobe_d_reg;
   assign sel_next    = (strobe_rise & bus_dir_out) ? bus_line_in[MY_LINE] : selected_reg;

   always_ff @(posedge mclk) begin
      if (rst) begin
         strobe_d_reg <= 1'b0;
         selected_reg <= 1'b0;
         polling_reg  <= 1'b0;
         bus_ack      <= 1'b0;
         bus_line_out <= 1'b0;
         bus_line_oe  <= 1'b0;
      end else begin
         strobe_d_reg <= strobe;
         selected_reg <= sel_next;
         if (strobe_rise)
            polling_reg <= ~bus_dir_out;
         else if (!strobe)
            polling_reg <= 1'b0;
         // ack held while strobe high so the controller sees it on the falling edge
         bus_ack      <= strobe & sel_next;
         bus_line_out <= attn_next;
         bus_line_oe  <= strobe & ((strobe_rise & ~bus_dir_out) | polling_reg);
      end
   end

   // revolution timing; sector zero's pulse is the index, so no sector pulse there
   always_ff @(posedge mclk) begin
      if (rst) begin
         sect_cnt_reg <= 16'h0000;
         sect_num_reg <= 8'h00;
         index_pulse  <= 1'b0;
         sector_pulse <= 1'b0;
      end else begin
         if (sect_cnt_reg == SECT_LAST) begin
            sect_cnt_reg <= 16'h0000;
            sect_num_reg <= (sect_num_reg == SECT_MAX) ? 8'h00 : sect_num_reg + 8'h01;
         end else begin
            sect_cnt_reg <= sect_cnt_reg + 16'h0001;
         end
         index_pulse  <= selected_reg & (sect_num_reg == 8'h00)
                         & (sect_cnt_reg < PULSE_W);
         sector_pulse <= selected_reg & (sect_num_reg != 8'h00)
                         & (sect_cnt_reg < PULSE_W);
      end
   end

   // summary bits and report answers
   always_ff @(posedge mclk) begin
      if (rst) begin
         gs_sense2_any  <= 1'b0;
         sb1_sense3_any <= 1'b0;
         sb1_diag_any   <= 1'b0;
         resp_data      <= 8'h00;
         resp_valid     <= 1'b0;
      end else begin
         gs_sense2_any  <= |sb2_next;
         sb1_sense3_any <= |sb3_next;
         sb1_diag_any   <= |diag_next;
         resp_valid     <= cmd.report_sense2 | cmd.report_sense3 | cmd.report_diag;
         if (cmd.report_sense3)
            resp_data <= sb3_reg;
         else if (cmd.report_diag)
            resp_data <= diag_reg;
         else if (cmd.report_sense2)
            resp_data <= sb2_reg;
      end
   end

   property p_init_state;
      @(posedge mclk) disable iff (rst) init_done |=> sb2_reg[`DSS_SB2_INIT_STATE];
   endproperty
   a_init_state: assert property (p_init_state) else $error("initial state not set");
   property p_ready_trans;
      @(posedge mclk) disable iff (rst) $changed(not_ready) |-> sb2_reg[`DSS_SB2_READY_TRANS];
   endproperty
   a_ready_trans: assert property (p_ready_trans) else $error("ready change lost");
   property p_reserved;
      @(posedge mclk) disable iff (rst)
         ((sb2_reg & `DSS_SB2_RSVD_MASK) == 8'h00) && ((sb3_reg & `DSS_SB3_RSVD_MASK) == 8'h00)
         && ((diag_reg & `DSS_DIAG_RSVD_MASK) == 8'h00);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");
   property p_report3;
      @(posedge mclk) disable iff (rst)
         cmd.report_sense3 |=> resp_valid && resp_data == $past(sb3_reg);
   endproperty
   a_report3: assert property (p_report3) else $error("third byte answer wrong");
   property p_spin_attn;
      @(posedge mclk) disable iff (rst) $rose(sb3_reg[`DSS_SB3_SPIN_ERR]) |-> attn_latch_reg;
   endproperty
   a_spin_attn: assert property (p_spin_attn) else $error("spin error no attention");
   property p_guard_busy;
      @(posedge mclk) disable iff (rst)
         $rose(sb3_reg[`DSS_SB3_GUARD_BAND]) |-> busy && auto_rezero_start;
   endproperty
   a_guard_busy: assert property (p_guard_busy) else $error("rezero not started");
   // busy must cover the whole automatic rezero, however long it runs
   property p_rezero_busy;
      @(posedge mclk) disable iff (rst)
         (rz_state_reg == dss_pkg::DSS_RZ_RUN) && !rezero_done |=> busy;
   endproperty
   a_rezero_busy: assert property (p_rezero_busy) else $error("busy dropped in rezero");
   property p_diag_nr;
      @(posedge mclk) disable iff (rst) (|diag_reg) |-> not_ready && sb1_diag_any;
   endproperty
   a_diag_nr: assert property (p_diag_nr) else $error("failed self test but ready");
   property p_deselect;
      @(posedge mclk) disable iff (rst)
         strobe_rise && bus_dir_out && bus_line_in == 8'h00 |=> !selected_reg ##1 !index_pulse;
   endproperty
   a_deselect: assert property (p_deselect) else $error("still selected");
   property p_poll;
      @(posedge mclk) disable iff (rst)
         strobe_rise && !bus_dir_out |=> bus_line_oe && bus_line_out == $past(attn_next);
   endproperty
   a_poll: assert property (p_poll) else $error("poll not answered");
   property p_index_gate;
      @(posedge mclk) disable iff (rst) (index_pulse || sector_pulse) |-> $past(selected_reg);
   endproperty
   a_index_gate: assert property (p_index_gate) else $error("pulse while deselected");
   property p_clear_attn;
      @(posedge mclk) disable iff (rst)
         cmd.clear_attention && !attn_set |=> !attn_latch_reg ##0 !attention;
   endproperty
   a_clear_attn: assert property (p_clear_attn) else $error("attention not released");

endmodule

// ==== dss_ctrl_model.sv ====
`timescale 1ns/1ps
// controller end of the select and poll strobe
module dss_ctrl_model (
   input  wire logic       mclk,
   input  wire logic       bus_ack,
   input  wire logic       dev_line,
   output logic            strobe,
   output logic            bus_dir_out,
   output logic [7:0]      lines
);
   initial begin
      strobe      = 1'b0;
      bus_dir_out = 1'b1;
      lines       = 8'h00;
   end
   // 25 cycles high meets the 500 ns strobe width; lines settle a cycle ahead
   task automatic sel(input logic [7:0] l, input logic dir, output logic [1:0] seen);
      @(negedge mclk);
      lines       = l;
      bus_dir_out = dir;
      @(negedge mclk);
      strobe = 1'b1;
      repeat (25) @(negedge mclk);
      seen   = {bus_ack, dev_line};
      strobe = 1'b0;
      @(negedge mclk);
      // terminated lines idle inactive once released
      lines       = 8'h00;
      bus_dir_out = 1'b1;
   endtask
endmodule

// ==== drive_sense_status_select_attention_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
   $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module drive_sense_status_select_attention_tb;
   int n_fail = 0, comparisons = 0, n_idx, n_sec;
   logic mclk = 1'b0, rst = 1'b1, attn_enable = 1'b1;
   logic [12:0] cmd_bits = 13'h0;
   logic init_done = 0, not_ready_in = 0, table_mod_bit = 0, protect_switch = 0;
   logic spin_up_start = 0, heads_outside_data = 0, rezero_done = 0, op_complete = 0;
   logic ram_fail = 0, prom1_fail = 0, prom2_fail = 0, fault_persists = 0, pi, ps;
   logic heads_in_protected = 0, spin_down_start = 0, at_speed = 0, osc_fault = 0;
   logic write_gate = 0, off_track = 0, park_lock_engaged = 0, cmd_param_error = 0;
   logic strobe, bus_dir_out, bus_line_out, bus_line_oe, bus_ack, busy, attention;
   logic not_ready, write_inhibit, index_pulse, sector_pulse, gs_sense2_any;
   logic sb1_sense3_any, sb1_diag_any, resp_valid;
   logic [7:0] lines, resp_data;
   logic [1:0] seen;
   always #10 mclk = ~mclk;
   dss_ctrl_model i_dss_ctrl_model (.mclk(mclk), .bus_ack(bus_ack),
      .dev_line(bus_line_oe & bus_line_out), .strobe(strobe), .bus_dir_out(bus_dir_out),
      .lines(lines));
   // short spin timeout and a 4 x 200 cycle revolution keep the run brief
   dss_status #(.MY_LINE(2), .SPIN_CYCLES(50), .SECTORS(4), .SECTOR_CYCLES(200)) i_dss_status (
      .mclk(mclk), .rst(rst), .cmd(dss_pkg::dss_cmd_t'(cmd_bits)), .init_done(init_done),
      .not_ready_in(not_ready_in), .table_mod_bit(table_mod_bit),
      .protect_switch(protect_switch), .heads_in_protected(heads_in_protected),
      .spin_up_start(spin_up_start), .spin_down_start(spin_down_start), .at_speed(at_speed),
      .spun_down(1'b0), .servo_phase_lock_oscillator_fault(osc_fault), .write_gate(write_gate),
      .off_track(off_track), .heads_outside_data(heads_outside_data), .rezero_active(1'b0),
      .outer_stop_active(1'b0), .rezero_done(rezero_done),
      .park_lock_engaged(park_lock_engaged), .ram_fail(ram_fail),
      .prom1_fail(prom1_fail), .prom2_fail(prom2_fail), .cmd_param_error(cmd_param_error),
      .op_complete(op_complete), .other_error(1'b0), .fault_persists(fault_persists),
      .attn_enable(attn_enable), .busy_in(1'b0), .strobe(strobe), .bus_dir_out(bus_dir_out),
      .bus_line_in(lines), .bus_line_out(bus_line_out), .bus_line_oe(bus_line_oe),
      .bus_ack(bus_ack), .busy(busy), .attention(attention), .not_ready(not_ready),
      .write_inhibit(write_inhibit), .auto_rezero_start(), .index_pulse(index_pulse),
      .sector_pulse(sector_pulse), .gs_sense2_any(gs_sense2_any),
      .sb1_sense3_any(sb1_sense3_any), .sb1_diag_any(sb1_diag_any), .resp_data(resp_data),
      .resp_valid(resp_valid));
   // one-cycle command; reports are checked in the answer cycle
   task automatic cmdp(input int b, input bit chk, input logic [7:0] e);
      @(negedge mclk);
      cmd_bits[b] = 1'b1;
      @(negedge mclk);
      cmd_bits[b] = 1'b0;
      if (chk) begin
         `CHK(resp_valid, 1'b1)
         `CHK(resp_data, e)
      end
      repeat (2) @(negedge mclk);
   endtask
   task automatic pls(ref logic s);
      @(negedge mclk);
      s = 1'b1;
      @(negedge mclk);
      s = 1'b0;
      repeat (3) @(negedge mclk);
   endtask
   // a window of exactly one revolution sees each pulse rise once
   task automatic count_rev();
      n_idx = 0;
      n_sec = 0;
      repeat (800) begin
         pi = index_pulse;
         ps = sector_pulse;
         @(negedge mclk);
         n_idx += int'(index_pulse & ~pi);
         n_sec += int'(sector_pulse & ~ps);
      end
   endtask
   task automatic tally_and_finish();
      if (n_fail == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      #400000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      cmdp(2, 1, 8'h00);
      pls(init_done);
      `CHK(attention, 1'b1)
      `CHK(gs_sense2_any, 1'b1)
      pls(table_mod_bit);
      cmdp(2, 1, 8'h21);
      cmdp(12, 0, 8'h00);
      `CHK(attention, 1'b0)
      not_ready_in = 1'b1;
      repeat (4) @(negedge mclk);
      cmdp(2, 1, 8'h02);
      cmdp(12, 0, 8'h00);
      not_ready_in = 1'b0;
      repeat (4) @(negedge mclk);
      cmdp(2, 1, 8'h02);
      cmdp(12, 0, 8'h00);
      cmdp(4, 0, 8'h00);
      cmdp(2, 1, 8'h40);
      cmdp(3, 0, 8'h00);
      cmdp(2, 1, 8'h00);
      heads_in_protected = 1'b1;
      cmdp(3, 0, 8'h00);
      cmdp(2, 1, 8'h40);
      heads_in_protected = 1'b0;
      cmdp(3, 0, 8'h00);
      cmdp(2, 1, 8'h00);
      protect_switch = 1'b1;
      repeat (2) @(negedge mclk);
      `CHK(write_inhibit, 1'b1)
      cmdp(9, 0, 8'h00);
      cmdp(2, 1, 8'h40);
      protect_switch = 1'b0;
      cmdp(3, 0, 8'h00);
      pls(op_complete);
      `CHK(attention, 1'b1)
      i_dss_ctrl_model.sel(8'h00, 1'b0, seen);
      `CHK(seen, 2'b01)
      attn_enable = 1'b0;
      repeat (2) @(negedge mclk);
      `CHK(attention, 1'b0)
      attn_enable = 1'b1;
      cmdp(12, 0, 8'h00);
      pls(cmd_param_error);
      `CHK(attention, 1'b1)
      cmdp(12, 0, 8'h00);
      i_dss_ctrl_model.sel(8'h04, 1'b1, seen);
      `CHK(seen, 2'b10)
      i_dss_ctrl_model.sel(8'h00, 1'b0, seen);
      `CHK(seen, 2'b10)
      i_dss_ctrl_model.sel(8'h04, 1'b1, seen);
      count_rev();
      `CHK(n_idx, 1)
      `CHK(n_sec, 3)
      i_dss_ctrl_model.sel(8'h00, 1'b1, seen);
      `CHK(seen, 2'b00)
      count_rev();
      `CHK(n_idx + n_sec, 0)
      at_speed = 1'b1;
      pls(spin_up_start);
      repeat (60) @(negedge mclk);
      `CHK(sb1_sense3_any, 1'b0)
      pls(spin_down_start);
      repeat (60) @(negedge mclk);
      cmdp(1, 1, 8'h01);
      `CHK(sb1_sense3_any, 1'b1)
      fault_persists = 1'b1;
      cmdp(11, 0, 8'h00);
      `CHK(attention, 1'b1)
      fault_persists = 1'b0;
      cmdp(11, 0, 8'h00);
      `CHK(attention, 1'b0)
      cmdp(1, 1, 8'h00);
      cmdp(8, 0, 8'h00);
      cmdp(1, 1, 8'h08);
      `CHK(not_ready, 1'b1)
      cmdp(10, 0, 8'h00);
      pls(heads_outside_data);
      `CHK(busy, 1'b1)
      cmdp(1, 1, 8'h04);
      pls(rezero_done);
      `CHK(busy, 1'b0)
      cmdp(10, 0, 8'h00);
      park_lock_engaged = 1'b1;
      pls(osc_fault);
      cmdp(1, 1, 8'h12);
      `CHK(not_ready, 1'b1)
      cmdp(10, 0, 8'h00);
      write_gate = 1'b1;
      pls(off_track);
      park_lock_engaged = 1'b0;
      cmdp(1, 1, 8'h02);
      write_gate = 1'b0;
      cmdp(10, 0, 8'h00);
      pls(ram_fail);
      pls(prom1_fail);
      pls(prom2_fail);
      cmdp(11, 0, 8'h00);
      cmdp(0, 1, 8'h07);
      `CHK(sb1_diag_any, 1'b1)
      `CHK(not_ready, 1'b1)
      tally_and_finish();
   end
endmodule
